// *** pocal_pkg.sv ***
// Package for the proximity offset calibration averaging block.
package pocal_pkg;
    localparam logic [7:0] CALIB_ADDR        = 8'h69;
    localparam logic [7:0] CALIBCFG_ADDR     = 8'h6a;
    localparam logic [7:0] OFFSET_LO_ADDR    = 8'hc7;
    localparam logic [7:0] OFFSET_HI_ADDR    = 8'hc8;
    localparam logic [7:0] CALIBCFG_RESET    = 8'h00;
    localparam int         BIT_KICKOFF       = 0;
    localparam int         BIT_BASELINE_LOAD = 7;
    localparam int         BIT_ZERO_TRIM     = 6;
    localparam int         BIT_SKIP_SEARCH   = 3;
    localparam int         AVG_SEL_LSB       = 0;
    localparam int         AVG_SEL_W         = 3;
    localparam int         DATA_W            = 14;
    localparam int         SEARCH_STEPS      = 8;
    localparam logic [7:0] OFFSET_RESET      = 8'h00;

    typedef enum logic [2:0] {
        POCAL_IDLE,
        POCAL_SEARCH,
        POCAL_AVERAGE,
        POCAL_LOAD,
        POCAL_DONE
    } pocal_phase_e;

    // Register write port.
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } pocal_wr_s;

    // One proximity result from the ADC.
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] value;
    } pocal_adc_s;
endpackage

// *** pocal_accum.sv ***
// Accumulator that sums proximity results and yields the power-of-two average.
`timescale 1ns/1ps
module pocal_accum #(
    parameter int DATA_W = 14,
    parameter int SEL_W  = 3
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clear,
    input  wire logic              add,
    input  wire logic [DATA_W-1:0] value,
    input  wire logic [SEL_W-1:0]  shift,
    output logic      [DATA_W-1:0] average
);
    localparam int SUM_W = DATA_W + (1 << SEL_W);

    typedef struct packed {
        logic [SUM_W-1:0]  sum;
        logic [DATA_W-1:0] average;
    } pocal_acc_s;

    pocal_acc_s st;
    pocal_acc_s next_st;

    always_comb begin
        next_st = st;
        if (clear) begin
            next_st.sum = '0;
        end else if (add) begin
            next_st.sum = st.sum + SUM_W'(value);
        end
        // Taken from the updated sum so that the last result already counts in the load cycle.
        next_st.average = DATA_W'(next_st.sum >> shift);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign average = st.average;
endmodule

// *** pocal_engine.sv ***
// Proximity offset calibration engine: search, DC averaging and baseline load.
//
// Contract
// - With baseline load set, the DC average goes into the proximity baseline at end.
// - With zero trim set, a zero result during averaging decrements a nonzero offset and sets trimmed flag.
// - After such a decrement averaging carries on without restarting.
// - With skip search set, the search step is omitted entirely.
// - Unless skip search is set, DC averaging runs only after the search phase has completed.
// - Count field 0 skips averaging, otherwise 2 to the n results are averaged.
// - Writing one to the kickoff bit starts calibration; results land in offset registers.
// - On completion set the done flag and raise interrupt if enabled.
// - Writing zero to the kickoff bit while running aborts at once.
`timescale 1ns/1ps
module pocal_engine #(
    parameter int SEARCH_STEPS = pocal_pkg::SEARCH_STEPS
) (
    input  wire logic                               clk,
    input  wire logic                               rst_n,
    input  wire pocal_pkg::pocal_wr_s               reg_wr,
    input  wire logic                               calibration_interrupt_enable,
    input  wire logic                               done_clear,
    input  wire pocal_pkg::pocal_adc_s              adc,
    input  wire logic                               search_high,
    output logic                                    measure_req,
    output logic [7:0]                              config_rd,
    output logic [7:0]                              proximity_offset,
    output logic [pocal_pkg::DATA_W-1:0]            proximity_baseline,
    output logic                                    calibration_running,
    output logic                                    calibration_done_flag,
    output logic                                    offset_trimmed_flag,
    output logic                                    calibration_interrupt
);
    import pocal_pkg::*;

    localparam logic [7:0] SEARCH_TOP = 8'(1 << (SEARCH_STEPS - 1));

    typedef struct packed {
        pocal_phase_e      phase;
        logic [7:0]        cfg;
        logic [7:0]        offset;
        logic [7:0]        search_bit;
        logic [8:0]        avg_left;
        logic [DATA_W-1:0] baseline;
        logic              done;
        logic              trimmed;
        logic              irq;
        logic              req;
        logic              running;
    } pocal_state_s;

    pocal_state_s st;
    pocal_state_s next_st;
    logic [DATA_W-1:0] average;
    logic              acc_clear;
    logic              acc_add;
    logic              kick_wr;
    logic              kick_one;
    logic [AVG_SEL_W-1:0] avg_sel;

    assign avg_sel  = st.cfg[AVG_SEL_LSB +: AVG_SEL_W];
    assign kick_wr  = reg_wr.wr && reg_wr.addr == CALIB_ADDR;
    assign kick_one = reg_wr.data[BIT_KICKOFF];

    pocal_accum #(
        .DATA_W (DATA_W),
        .SEL_W  (AVG_SEL_W)
    ) u_accum (
        .clk     (clk),
        .rst_n   (rst_n),
        .clear   (acc_clear),
        .add     (acc_add),
        .value   (adc.value),
        .shift   (avg_sel),
        .average (average)
    );

    always_comb begin
        next_st   = st;
        acc_clear = 1'b0;
        acc_add   = 1'b0;
        next_st.irq = 1'b0;
        if (reg_wr.wr && reg_wr.addr == CALIBCFG_ADDR) begin
            next_st.cfg = reg_wr.data & 8'hcf;
        end
        if (reg_wr.wr && reg_wr.addr == OFFSET_LO_ADDR) begin
            next_st.offset = reg_wr.data;
        end
        if (done_clear) begin
            next_st.done    = 1'b0;
            next_st.trimmed = 1'b0;
        end
        unique case (st.phase)
            POCAL_IDLE: begin
                if (kick_wr && kick_one) begin
                    acc_clear = 1'b1;
                    next_st.done = 1'b0;
                    if (st.cfg[BIT_SKIP_SEARCH]) begin
                        next_st.phase = (avg_sel == '0) ? POCAL_LOAD : POCAL_AVERAGE;
                        next_st.avg_left = 9'h001 << avg_sel;
                    end else begin
                        next_st.phase      = POCAL_SEARCH;
                        next_st.offset     = SEARCH_TOP;
                        next_st.search_bit = SEARCH_TOP;
                    end
                    next_st.req = 1'b1;
                end
            end
            POCAL_SEARCH: begin
                if (adc.valid) begin
                    // Too high a result keeps the trial bit set; otherwise it is cleared.
                    if (!search_high) begin
                        next_st.offset = st.offset & ~st.search_bit;
                    end
                    next_st.search_bit = st.search_bit >> 1;
                    next_st.offset     = next_st.offset | (st.search_bit >> 1);
                    if (st.search_bit == 8'h01) begin
                        next_st.offset   = st.offset & ~(search_high ? 8'h00 : 8'h01);
                        next_st.phase    = (avg_sel == '0) ? POCAL_LOAD : POCAL_AVERAGE;
                        next_st.avg_left = 9'h001 << avg_sel;
                        next_st.req      = (avg_sel != '0);
                    end
                end
            end
            POCAL_AVERAGE: begin
                if (adc.valid) begin
                    acc_add = 1'b1;
                    if (st.cfg[BIT_ZERO_TRIM] && adc.value == '0 && st.offset != '0) begin
                        next_st.offset  = st.offset - 8'h01;
                        next_st.trimmed = 1'b1;
                    end
                    // Averaging keeps counting after a trim.
                    next_st.avg_left = st.avg_left - 9'h001;
                    if (st.avg_left == 9'h001) begin
                        next_st.phase = POCAL_LOAD;
                        next_st.req   = 1'b0;
                    end
                end
            end
            POCAL_LOAD: begin
                next_st.req = 1'b0;
                if (st.cfg[BIT_BASELINE_LOAD] && avg_sel != '0) begin
                    next_st.baseline = average;
                end
                next_st.phase = POCAL_DONE;
            end
            POCAL_DONE: begin
                next_st.done  = 1'b1;
                next_st.irq   = calibration_interrupt_enable;
                next_st.phase = POCAL_IDLE;
            end
            default: next_st.phase = POCAL_IDLE;
        endcase
        if (kick_wr && !kick_one && st.phase != POCAL_IDLE) begin
            next_st.phase = POCAL_IDLE;
            next_st.req   = 1'b0;
            next_st.irq   = 1'b0;
        end
        next_st.running = next_st.phase != POCAL_IDLE;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st       <= '0;
            st.phase <= POCAL_IDLE;
            st.cfg   <= CALIBCFG_RESET;
            st.offset <= OFFSET_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign measure_req           = st.req;
    assign config_rd             = st.cfg;
    assign proximity_offset      = st.offset;
    assign proximity_baseline    = st.baseline;
    assign calibration_running   = st.running;
    assign calibration_done_flag = st.done;
    assign offset_trimmed_flag   = st.trimmed;
    assign calibration_interrupt = st.irq;

    property p_abort;
        @(posedge clk) disable iff (!rst_n)
        (kick_wr && !kick_one && st.phase != POCAL_IDLE) |=> st.phase == POCAL_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not stop calibration");

    property p_trim;
        @(posedge clk) disable iff (!rst_n)
        (st.phase == POCAL_AVERAGE && adc.valid && st.cfg[BIT_ZERO_TRIM] && adc.value == '0
         && st.offset != '0 && !done_clear && !kick_wr)
        |=> st.offset == $past(st.offset) - 8'h01 && st.trimmed;
    endproperty
    a_trim: assert property (p_trim) else $error("zero result did not trim offset");

    property p_continue;
        @(posedge clk) disable iff (!rst_n)
        (st.phase == POCAL_AVERAGE && adc.valid && st.avg_left > 9'h001 && !kick_wr)
        |=> st.phase == POCAL_AVERAGE && st.avg_left == $past(st.avg_left) - 9'h001;
    endproperty
    a_continue: assert property (p_continue) else $error("averaging restarted");

    property p_skip;
        @(posedge clk) disable iff (!rst_n)
        (st.phase == POCAL_IDLE && kick_wr && kick_one && st.cfg[BIT_SKIP_SEARCH])
        |=> st.phase != POCAL_SEARCH;
    endproperty
    a_skip: assert property (p_skip) else $error("search not skipped");

    property p_order;
        @(posedge clk) disable iff (!rst_n)
        st.phase == POCAL_AVERAGE |=> st.phase != POCAL_SEARCH;
    endproperty
    a_order: assert property (p_order) else $error("search after averaging");

    property p_count;
        @(posedge clk) disable iff (!rst_n)
        $rose(st.phase == POCAL_AVERAGE) |-> st.avg_left == (9'h001 << avg_sel);
    endproperty
    a_count: assert property (p_count) else $error("wrong averaging count");

    property p_done;
        @(posedge clk) disable iff (!rst_n)
        (st.phase == POCAL_LOAD && !kick_wr) |=> ##1 st.done && st.irq == $past(calibration_interrupt_enable);
    endproperty
    a_done: assert property (p_done) else $error("completion not signalled");

    property p_load;
        @(posedge clk) disable iff (!rst_n)
        (st.phase == POCAL_LOAD && st.cfg[BIT_BASELINE_LOAD] && avg_sel != '0 && !kick_wr)
        |=> st.baseline == $past(average);
    endproperty
    a_load: assert property (p_load) else $error("baseline not loaded");

    property p_kick;
        @(posedge clk) disable iff (!rst_n)
        (st.phase == POCAL_IDLE && kick_wr && kick_one) |=> st.phase != POCAL_IDLE && st.req;
    endproperty
    a_kick: assert property (p_kick) else $error("kickoff did not start");
endmodule

// *** pocal_engine_bench.sv ***
// Self-checking testbench for the proximity offset calibration engine.
`timescale 1ns/1ps
module pocal_engine_bench;
    import pocal_pkg::*;
    logic                clk;
    logic                rst_n;
    pocal_wr_s           reg_wr;
    logic                irq_en;
    logic                done_clear;
    pocal_adc_s          adc;
    logic                search_high;
    logic                measure_req;
    logic [7:0]          config_rd;
    logic [7:0]          offset;
    logic [DATA_W-1:0]   baseline;
    logic                running;
    logic                done;
    logic                trimmed;
    logic                irq;
    int                  mismatches;
    int                  checks;

    pocal_engine dut (
        .clk                          (clk),
        .rst_n                        (rst_n),
        .reg_wr                       (reg_wr),
        .calibration_interrupt_enable (irq_en),
        .done_clear                   (done_clear),
        .adc                          (adc),
        .search_high                  (search_high),
        .measure_req                  (measure_req),
        .config_rd                    (config_rd),
        .proximity_offset             (offset),
        .proximity_baseline           (baseline),
        .calibration_running          (running),
        .calibration_done_flag        (done),
        .offset_trimmed_flag          (trimmed),
        .calibration_interrupt        (irq)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic give_verdict();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask

    // An idle cycle after each write keeps the strobe from being lowered and raised at once.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        reg_wr = '{wr: 1'b1, addr: addr, data: data};
        @(negedge clk);
        reg_wr.wr = 1'b0;
        @(negedge clk);
    endtask

    // Each result is followed by an idle cycle so valid never toggles twice at once.
    task automatic feed(input logic [DATA_W-1:0] v);
        adc = '{valid: 1'b1, value: v};
        @(negedge clk);
        adc.valid = 1'b0;
        @(negedge clk);
    endtask

    task automatic clear_flags();
        done_clear = 1'b1;
        @(negedge clk);
        done_clear = 1'b0;
        @(negedge clk);
    endtask

    task automatic wait_done();
        int n;
        for (n = 0; n < 40 && done !== 1'b1; n++) begin
            @(negedge clk);
        end
        if (done !== 1'b1) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, done, 1'b1);
            mismatches++;
            give_verdict();
        end
    endtask

    initial begin
        rst_n = 1'b0;
        reg_wr = '0;
        irq_en = 1'b0;
        done_clear = 1'b0;
        adc = '0;
        search_high = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk(config_rd, 16'h0000);
        chk(offset, 16'h0000);
        chk({running, done, trimmed, irq}, 16'h0000);
        wr(CALIBCFG_ADDR, 8'hff);
        wr(8'h55, 8'h00);
        chk(config_rd, 16'h00cf);
        // Skip search, two results, baseline load, interrupt enabled.
        irq_en = 1'b1;
        wr(CALIBCFG_ADDR, 8'h89);
        wr(CALIB_ADDR, 8'h01);
        chk(running, 16'h0001);
        chk(measure_req, 16'h0001);
        feed(14'h000a);
        feed(14'h0014);
        wait_done();
        chk(irq, 16'h0001);
        chk(baseline, 16'h000f);
        chk(running, 16'h0000);
        chk(measure_req, 16'h0000);
        clear_flags();
        // Full search first, then no averaging.
        wr(CALIBCFG_ADDR, 8'h00);
        wr(CALIB_ADDR, 8'h01);
        for (int i = 0; i < 7; i++) begin
            search_high = i[0];
            feed(14'h0100);
        end
        chk({running, done}, 16'h0002);
        feed(14'h0100);
        wait_done();
        chk(baseline, 16'h000f);
        chk(offset, 16'h0054);
        clear_flags();
        // Zero readings trim the offset while averaging carries on.
        wr(OFFSET_LO_ADDR, 8'h10);
        wr(CALIBCFG_ADDR, 8'hc9);
        wr(CALIB_ADDR, 8'h01);
        feed(14'h0000);
        chk(offset, 16'h000f);
        chk({running, trimmed}, 16'h0003);
        feed(14'h0008);
        wait_done();
        chk(baseline, 16'h0004);
        clear_flags();
        chk({done, trimmed}, 16'h0000);
        // Abort in mid averaging.
        wr(CALIBCFG_ADDR, 8'h0a);
        wr(CALIB_ADDR, 8'h01);
        feed(14'h0020);
        wr(CALIB_ADDR, 8'h00);
        chk(running, 16'h0000);
        repeat (4) @(negedge clk);
        chk({done, irq}, 16'h0000);
        // Software restarts averaging after the abort: largest count, interrupt disabled.
        irq_en = 1'b0;
        wr(CALIBCFG_ADDR, 8'h8f);
        wr(CALIB_ADDR, 8'h01);
        for (int i = 0; i < 127; i++) begin
            feed(14'h0064);
        end
        chk({running, done}, 16'h0002);
        feed(14'h0064);
        wait_done();
        chk(irq, 16'h0000);
        chk(baseline, 16'h0064);
        give_verdict();
    end
endmodule
